// ---- hw/fcg_cmd_gate.sv ----
/*
 * Admission table: tells whether a command code may run in the present
 * chip mode and security state.
 * Assumes mode and security inputs are already synchronous to the clock.
 */
`timescale 1ns/1ps
`default_nettype none
module fcg_cmd_gate (
    // Command and state.
    input  wire logic [7:0] code,
    input  wire logic       special,
    input  wire logic       secured,
    // Verdict.
    output logic            allowed
);
    import fcg_pkg::*;

    always_comb begin
        case (code)
            CMD_EV_ALL, CMD_EV_BLOCK: begin
                allowed = 1'b1;
            end
            CMD_EV_SECTION, CMD_READ_ONCE, CMD_PROGRAM, CMD_PROG_ONCE,
            CMD_ERASE_BLK, CMD_ERASE_SEC, CMD_USER_MRG,
            CMD_EE_VERIFY, CMD_EE_PROGRAM, CMD_EE_ERASE: begin
                allowed = !(special && secured);
            end
            CMD_ERASE_ALL, CMD_UNSECURE: begin
                allowed = special;
            end
            CMD_KEY_VERIFY: begin
                allowed = !special;
            end
            CMD_FIELD_MRG: begin
                allowed = special && !secured;
            end
            default: begin
                allowed = 1'b0;
            end
        endcase
    end

endmodule // fcg_cmd_gate
`default_nettype wire

// ---- hw/fcg_top.sv ----
/*
 * Register front end and command admission for the embedded flash
 * controller, reached over AXI4-Lite.
 * Assumes an external engine runs admitted array commands and reports
 * completion on CMD_DONE; mode, security and key inputs are synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module fcg_top #(
    parameter int ADDR_W = 8
) (
    // Clock, reset, enable.
    input  wire logic              MCLK,
    input  wire logic              RST_B,
    input  wire logic              CE,
    // AXI4-Lite write address.
    input  wire logic [ADDR_W-1:0] AWADDR,
    input  wire logic              AWVALID,
    output logic                   AWREADY,
    // AXI4-Lite write data.
    input  wire logic [31:0]       WDATA,
    input  wire logic [3:0]        WSTRB,
    input  wire logic              WVALID,
    output logic                   WREADY,
    // AXI4-Lite write response.
    output logic [1:0]             BRESP,
    output logic                   BVALID,
    input  wire logic              BREADY,
    // AXI4-Lite read address.
    input  wire logic [ADDR_W-1:0] ARADDR,
    input  wire logic              ARVALID,
    output logic                   ARREADY,
    // AXI4-Lite read data.
    output logic [31:0]            RDATA,
    output logic [1:0]             RRESP,
    output logic                   RVALID,
    input  wire logic              RREADY,
    // Chip mode and security.
    input  wire logic              SPECIAL_MODE_INPUT,
    input  wire logic              SECURE_INPUT,
    input  wire logic [1:0]        KEY_ACCESS_ENABLE_FIELD,
    input  wire logic [63:0]       BACKDOOR_KEY,
    output logic                   SECURITY_RELEASED,
    // Array command engine.
    output logic                   CMD_START,
    output logic [7:0]             COMMAND_CODE,
    output logic                   VERIFY_EEPROM_TOO,
    input  wire logic              CMD_DONE,
    // Read path controls and interrupt.
    output logic                   IGNORE_SINGLE_FAULT,
    output logic                   FORCE_SINGLE_FAULT,
    output logic                   FORCE_DOUBLE_FAULT,
    output logic                   COMMAND_DONE_IRQ
);
    import fcg_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic              aw_got_reg;
    logic [7:0]        awaddr_reg;
    logic              w_got_reg;
    logic [31:0]       wdata_reg;
    logic [3:0]        wstrb_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              rvalid_reg;
    logic [31:0]       rdata_reg;
    logic [1:0]        rresp_reg;
    logic [7:0]        rd_addr_reg;
    logic [IDX_W-1:0]  index_reg;
    logic [7:0]        config_reg;
    logic [15:0]       cmd_words [0:7];
    logic              ccf_reg;
    logic              access_error_flag_reg;
    logic              released_reg;
    logic              start_reg;
    logic [7:0]        code_reg;
    logic              ev_all_reg;
    fcg_state_t        state_reg;
    logic              wr_do;
    logic              rd_do;
    logic              wr_hit;
    logic              launch;
    logic              special;
    logic              secured;
    logic              gate_ok;
    logic              key_ok;
    logic              admit;
    logic              key_match;
    logic [7:0]        ar_low;
    logic [31:0]       rd_mux;
    logic              rd_hit;

    ////////////////////////////////////////////////////////////////////////
    // Mode and admission.

    assign special = SPECIAL_MODE_INPUT;
    assign secured = SECURE_INPUT && !released_reg;
    assign key_ok  = (KEY_ACCESS_ENABLE_FIELD == KEY_ACCESS_ENABLE_FIELD_ON);

    fcg_cmd_gate u_gate (
        .code    (cmd_words[0][15:8]),
        .special (special),
        .secured (secured),
        .allowed (gate_ok)
    );

    // The key verify also needs the backdoor to be opened by the key field.
    assign admit = gate_ok && (cmd_words[0][15:8] != CMD_KEY_VERIFY || key_ok);
    assign key_match = ({cmd_words[1], cmd_words[2], cmd_words[3], cmd_words[4]}
                        == BACKDOOR_KEY);

    ////////////////////////////////////////////////////////////////////////
    // Write channel.

    assign AWREADY = !aw_got_reg;
    assign WREADY  = !w_got_reg;
    assign BVALID  = bvalid_reg;
    assign BRESP   = bresp_reg;
    assign wr_do   = aw_got_reg && w_got_reg && !bvalid_reg;
    assign wr_hit  = (awaddr_reg == OFS_SECURITY) || (awaddr_reg == OFS_INDEX)
                  || (awaddr_reg == OFS_CONFIG) || (awaddr_reg == OFS_RSV_ZERO)
                  || (awaddr_reg == OFS_RSV_TWO) || (awaddr_reg == OFS_CMD_WORD)
                  || (awaddr_reg == OFS_STATUS);
    assign launch  = wr_do && (awaddr_reg == OFS_STATUS) && wstrb_reg[0]
                  && wdata_reg[STAT_CCF_BIT] && ccf_reg;

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            aw_got_reg <= 1'b0;
            awaddr_reg <= 8'h00;
        end else if (CE) begin
            if (AWVALID && !aw_got_reg) begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= 8'(AWADDR);
            end else if (wr_do) begin
                aw_got_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            w_got_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else if (CE) begin
            if (WVALID && !w_got_reg) begin
                w_got_reg <= 1'b1;
                wdata_reg <= WDATA;
                wstrb_reg <= WSTRB;
            end else if (wr_do) begin
                w_got_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (CE) begin
            if (wr_do) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (BREADY) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers.

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            index_reg <= IDX_RESET;
        end else if (CE && wr_do && awaddr_reg == OFS_INDEX && wstrb_reg[0]) begin
            index_reg <= wdata_reg[IDX_W-1:0];
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            config_reg <= CFG_RESET;
        end else if (CE && wr_do && awaddr_reg == OFS_CONFIG && wstrb_reg[0]) begin
            config_reg <= '0;
            config_reg[CFG_IRQ_EN_BIT]   <= wdata_reg[CFG_IRQ_EN_BIT];
            config_reg[CFG_IGN_SF_BIT]   <= wdata_reg[CFG_IGN_SF_BIT];
            config_reg[CFG_FORCE_DF_BIT] <= wdata_reg[CFG_FORCE_DF_BIT];
            config_reg[CFG_FORCE_SF_BIT] <= wdata_reg[CFG_FORCE_SF_BIT];
        end
    end

    // Words are held while a command runs so the key verify compares stable data.
    always_ff @(posedge MCLK) begin
        if (CE && wr_do && awaddr_reg == OFS_CMD_WORD && ccf_reg) begin
            if (wstrb_reg[1]) begin
                cmd_words[index_reg][15:8] <= wdata_reg[15:8];
            end
            if (wstrb_reg[0]) begin
                cmd_words[index_reg][7:0] <= wdata_reg[7:0];
            end
        end
    end

    assign IGNORE_SINGLE_FAULT = config_reg[CFG_IGN_SF_BIT];
    assign FORCE_SINGLE_FAULT  = config_reg[CFG_FORCE_SF_BIT];
    assign FORCE_DOUBLE_FAULT  = config_reg[CFG_FORCE_DF_BIT];
    assign COMMAND_DONE_IRQ    = config_reg[CFG_IRQ_EN_BIT] && ccf_reg;

    ////////////////////////////////////////////////////////////////////////
    // Command sequencer and status.

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg    <= FCG_IDLE;
            ccf_reg      <= 1'b1;
            released_reg <= 1'b0;
            start_reg    <= 1'b0;
            code_reg     <= 8'h00;
            ev_all_reg   <= 1'b0;
        end else if (CE) begin
            start_reg <= 1'b0;
            case (state_reg)
                FCG_IDLE: begin
                    if (launch && admit) begin
                        ccf_reg   <= 1'b0;
                        code_reg  <= cmd_words[0][15:8];
                        state_reg <= FCG_EXEC;
                    end
                end
                FCG_EXEC: begin
                    if (code_reg == CMD_KEY_VERIFY) begin
                        if (key_match) begin
                            released_reg <= 1'b1;
                        end
                        ccf_reg   <= 1'b1;
                        state_reg <= FCG_IDLE;
                    end else begin
                        start_reg  <= 1'b1;
                        ev_all_reg <= (code_reg == CMD_EV_ALL);
                        state_reg  <= FCG_WAIT;
                    end
                end
                FCG_WAIT: begin
                    if (CMD_DONE) begin
                        ccf_reg   <= 1'b1;
                        state_reg <= FCG_IDLE;
                    end
                end
                default: begin
                    state_reg <= FCG_IDLE;
                end
            endcase
        end
    end

    // A refusal in the same cycle as a software clear keeps the flag set.
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            access_error_flag_reg <= 1'b0;
        end else if (CE) begin
            if (launch && !admit) begin
                access_error_flag_reg <= 1'b1;
            end else if (wr_do && awaddr_reg == OFS_STATUS && wstrb_reg[0]
                         && wdata_reg[STAT_ACCESS_ERROR_FLAG_BIT]) begin
                access_error_flag_reg <= 1'b0;
            end
        end
    end

    assign SECURITY_RELEASED = released_reg;
    assign CMD_START         = start_reg;
    assign COMMAND_CODE      = code_reg;
    assign VERIFY_EEPROM_TOO = ev_all_reg;

    ////////////////////////////////////////////////////////////////////////
    // Read channel.

    assign ARREADY = !rvalid_reg;
    assign RVALID  = rvalid_reg;
    assign RDATA   = rdata_reg;
    assign RRESP   = rresp_reg;
    assign rd_do   = ARVALID && !rvalid_reg;
    assign ar_low  = 8'(ARADDR);

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (ar_low)
            OFS_SECURITY: begin
                rd_mux[1:0]             = KEY_ACCESS_ENABLE_FIELD;
                rd_mux[SEC_SPECIAL_BIT] = special;
                rd_mux[SEC_SECURED_BIT] = secured;
            end
            OFS_INDEX: begin
                rd_mux[IDX_W-1:0] = index_reg;
            end
            OFS_CONFIG: begin
                rd_mux[7:0] = config_reg;
            end
            OFS_RSV_ZERO, OFS_RSV_TWO: begin
                rd_mux = 32'h0000_0000;
            end
            OFS_CMD_WORD: begin
                rd_mux[15:0] = cmd_words[index_reg];
            end
            OFS_STATUS: begin
                rd_mux[STAT_CCF_BIT]    = ccf_reg;
                rd_mux[STAT_ACCESS_ERROR_FLAG_BIT] = access_error_flag_reg;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= RESP_OKAY;
            rd_addr_reg <= 8'h00;
        end else if (CE) begin
            if (rd_do) begin
                rvalid_reg  <= 1'b1;
                rdata_reg   <= rd_mux;
                rresp_reg   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
                rd_addr_reg <= ar_low;
            end else if (RREADY) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge MCLK iff CE); endclocking
    default disable iff (!RST_B);

    property p_idx_read;
        rvalid_reg && rd_addr_reg == OFS_INDEX |-> rdata_reg[31:IDX_W] == '0;
    endproperty
    a_idx_read: assert property (p_idx_read) else $error("index upper bits");

    property p_rsv_read;
        rvalid_reg && (rd_addr_reg == OFS_RSV_ZERO || rd_addr_reg == OFS_RSV_TWO)
            |-> rdata_reg == 32'h0000_0000 && rresp_reg == RESP_OKAY;
    endproperty
    a_rsv_read: assert property (p_rsv_read) else $error("reserved not zero");

    property p_cfg_read;
        rvalid_reg && rd_addr_reg == OFS_CONFIG |-> rdata_reg[6:5] == 2'h0
            && rdata_reg[3:2] == 2'h0 && rdata_reg[31:8] == '0;
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("config spare bits");

    property p_refuse;
        launch && !admit |=> access_error_flag_reg && ccf_reg && state_reg == FCG_IDLE;
    endproperty
    a_refuse: assert property (p_refuse) else $error("refusal not flagged");

    property p_key_deny;
        launch && cmd_words[0][15:8] == CMD_KEY_VERIFY && !key_ok
            |=> access_error_flag_reg && $stable(released_reg);
    endproperty
    a_key_deny: assert property (p_key_deny) else $error("key verify not refused");

    property p_key_match;
        state_reg == FCG_EXEC && code_reg == CMD_KEY_VERIFY && key_match
            |=> released_reg && ccf_reg;
    endproperty
    a_key_match: assert property (p_key_match) else $error("keys did not release");

    property p_key_miss;
        state_reg == FCG_EXEC && code_reg == CMD_KEY_VERIFY && !key_match
            |=> $stable(released_reg) && ccf_reg;
    endproperty
    a_key_miss: assert property (p_key_miss) else $error("mismatch changed state");

    property p_normal_erase_all;
        launch && !special && cmd_words[0][15:8] == CMD_ERASE_ALL
            |=> access_error_flag_reg ##1 !start_reg;
    endproperty
    a_normal_erase_all: assert property (p_normal_erase_all) else $error("erase all ran");

    property p_ev_all_start;
        launch && admit && cmd_words[0][15:8] == CMD_EV_ALL
            |=> !ccf_reg ##1 start_reg && VERIFY_EEPROM_TOO;
    endproperty
    a_ev_all_start: assert property (p_ev_all_start) else $error("verify all not started");

    property p_irq;
        state_reg == FCG_WAIT && CMD_DONE
            |=> ccf_reg && COMMAND_DONE_IRQ == config_reg[CFG_IRQ_EN_BIT];
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    c_launch: cover property (launch && admit);
    c_refuse: cover property (launch && !admit);
    c_release: cover property ($rose(released_reg));

endmodule // fcg_top
`default_nettype wire

// ---- pkg/fcg_pkg.sv ----
/*
 * Constants for the flash command gating front end: register offsets,
 * field positions, reset values and command codes.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
package fcg_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFS_SECURITY  = 8'h00;
    localparam logic [7:0] OFS_INDEX     = 8'h04;
    localparam logic [7:0] OFS_CONFIG    = 8'h08;
    localparam logic [7:0] OFS_RSV_ZERO  = 8'h0c;
    localparam logic [7:0] OFS_RSV_TWO   = 8'h10;
    localparam logic [7:0] OFS_CMD_WORD  = 8'h14;
    localparam logic [7:0] OFS_STATUS    = 8'h18;

    // Field positions.
    localparam int IDX_W            = 3;
    localparam int CFG_IRQ_EN_BIT   = 7;
    localparam int CFG_IGN_SF_BIT   = 4;
    localparam int CFG_FORCE_DF_BIT = 1;
    localparam int CFG_FORCE_SF_BIT = 0;
    localparam int STAT_CCF_BIT     = 7;
    localparam int STAT_ACCESS_ERROR_FLAG_BIT  = 5;
    localparam int SEC_SECURED_BIT  = 7;
    localparam int SEC_SPECIAL_BIT  = 6;

    // Reset values.
    localparam logic [2:0] IDX_RESET = 3'h0;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // Key access enable field value that permits the backdoor.
    localparam logic [1:0] KEY_ACCESS_ENABLE_FIELD_ON = 2'h2;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Command codes.
    localparam logic [7:0] CMD_EV_ALL     = 8'h01;
    localparam logic [7:0] CMD_EV_BLOCK   = 8'h02;
    localparam logic [7:0] CMD_EV_SECTION = 8'h03;
    localparam logic [7:0] CMD_READ_ONCE  = 8'h04;
    localparam logic [7:0] CMD_PROGRAM    = 8'h06;
    localparam logic [7:0] CMD_PROG_ONCE  = 8'h07;
    localparam logic [7:0] CMD_ERASE_ALL  = 8'h08;
    localparam logic [7:0] CMD_ERASE_BLK  = 8'h09;
    localparam logic [7:0] CMD_ERASE_SEC  = 8'h0a;
    localparam logic [7:0] CMD_UNSECURE   = 8'h0b;
    localparam logic [7:0] CMD_KEY_VERIFY = 8'h0c;
    localparam logic [7:0] CMD_USER_MRG   = 8'h0d;
    localparam logic [7:0] CMD_FIELD_MRG  = 8'h0e;
    localparam logic [7:0] CMD_EE_VERIFY  = 8'h10;
    localparam logic [7:0] CMD_EE_PROGRAM = 8'h11;
    localparam logic [7:0] CMD_EE_ERASE   = 8'h12;

    typedef enum logic [1:0] {
        FCG_IDLE,
        FCG_EXEC,
        FCG_WAIT
    } fcg_state_t;

endpackage

// ---- verification/tb_top.sv ----
/*
 * Self-checking bench for the flash command gating front end.
 * Assumes fcg_pkg and fcg_top are compiled first; the bench is the AXI4-Lite master.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fcg_pkg::*;
    logic        mclk = 0, rst_b = 0, cmd_done = 1, sp = 0, se = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, rel, start, eetoo, isf, fsf, fdf, irq;
    logic [1:0]  bresp, rresp, key_access_enable_field = 0, resp;
    logic [7:0]  ccode;
    logic        ok;
    int          miscompares = 0, checks = 0, starts = 0, s0;
    logic [7:0]  codes [17] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a,
                                8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h10, 8'h11, 8'h12, 8'h05};
    always #5 mclk = ~mclk;
    always @(posedge mclk) if (start === 1'b1) starts <= starts + 1;
    fcg_top i_fcg_top (.MCLK(mclk), .RST_B(rst_b), .CE(1'b1), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .SPECIAL_MODE_INPUT(sp), .SECURE_INPUT(se), .KEY_ACCESS_ENABLE_FIELD(key_access_enable_field),
        .BACKDOOR_KEY(64'h1122334455667788), .SECURITY_RELEASED(rel), .CMD_START(start),
        .COMMAND_CODE(ccode), .VERIFY_EEPROM_TOO(eetoo), .CMD_DONE(cmd_done),
        .IGNORE_SINGLE_FAULT(isf), .FORCE_SINGLE_FAULT(fsf), .FORCE_DOUBLE_FAULT(fdf),
        .COMMAND_DONE_IRQ(irq));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic timeout();
        miscompares++;
        $display("BAD %0t no answer", $time);
        final_report();
    endtask
    // Address and data are offered together and each is dropped once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        @(posedge mclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid) break;
        end
        if (n == 50) timeout();
        resp = bresp;
        bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        int n;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid) break;
        end
        if (n == 50) timeout();
        v = rdata;
        resp = rresp;
        rready <= 0;
    endtask
    // Loads the code word, launches, waits for the complete flag, returns status.
    task automatic launch(input logic [7:0] c, output logic [31:0] st);
        int n;
        wr(OFS_INDEX, 32'h0);
        wr(OFS_CMD_WORD, {16'h0, c, 8'h00});
        wr(OFS_STATUS, 32'h80);
        for (n = 0; n < 40; n++) begin
            rd(OFS_STATUS, st);
            if (st[STAT_CCF_BIT] === 1'b1) break;
        end
        if (n == 40) timeout();
    endtask
    function automatic logic allowed(input logic [7:0] c, input logic s, input logic x);
        case (c)
            8'h01, 8'h02: return 1;
            8'h08, 8'h0b: return s;
            8'h0c:        return !s && key_access_enable_field == KEY_ACCESS_ENABLE_FIELD_ON;
            8'h0e:        return s && !x;
            8'h03, 8'h04, 8'h06, 8'h07, 8'h09, 8'h0a, 8'h0d, 8'h10, 8'h11, 8'h12: return !(s && x);
            default:      return 0;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge mclk);
        rst_b <= 1;
        rd(OFS_CONFIG, d);
        chk(d, 32'h0);
        rd(OFS_INDEX, d);
        chk(d, 32'h0);
        wr(OFS_INDEX, 32'hffff_fffd);
        rd(OFS_INDEX, d);
        chk(d, 32'h5);
        wr(OFS_CONFIG, 32'hffff_ffff);
        rd(OFS_CONFIG, d);
        chk(d, 32'h93);
        chk({isf, fsf, fdf}, 3'b111);
        wr(OFS_RSV_ZERO, 32'hffff_ffff);
        chk(resp, RESP_OKAY);
        rd(OFS_RSV_ZERO, d);
        chk(d, 32'h0);
        wr(OFS_RSV_TWO, 32'hffff_ffff);
        rd(OFS_RSV_TWO, d);
        chk(d, 32'h0);
        wr(8'h40, 32'h0);
        chk(resp, RESP_SLVERR);
        rd(8'h40, d);
        chk(resp, RESP_SLVERR);
        chk(d, 32'h0);
        wr(OFS_CONFIG, 32'h80);
        chk({isf, fsf, fdf}, 3'b000);
        for (int m = 0; m < 4; m++) begin
            sp <= m[1];
            se <= m[0];
            rd(OFS_SECURITY, d);
            chk(d & 32'hc0, {m[0], m[1], 6'h0});
            foreach (codes[i]) begin
                s0 = starts;
                ok = allowed(codes[i], m[1], m[0]);
                launch(codes[i], d);
                chk(d[STAT_ACCESS_ERROR_FLAG_BIT], !ok);
                chk(starts - s0, ok && codes[i] != CMD_KEY_VERIFY);
                if (ok) chk(ccode, codes[i]);
                if (ok && codes[i] != CMD_KEY_VERIFY) chk(eetoo, codes[i] == CMD_EV_ALL);
                chk(irq, 1'b1);
                wr(OFS_STATUS, 32'h20);
            end
        end
        wr(OFS_CONFIG, 32'h0);
        chk(irq, 1'b0);
        sp <= 0;
        se <= 1;
        key_access_enable_field <= KEY_ACCESS_ENABLE_FIELD_ON;
        for (int w = 1; w < 5; w++) begin
            wr(OFS_INDEX, w);
            wr(OFS_CMD_WORD, 32'h0);
        end
        launch(CMD_KEY_VERIFY, d);
        chk({d[STAT_ACCESS_ERROR_FLAG_BIT], rel}, 2'b00);
        for (int w = 1; w < 5; w++) begin
            wr(OFS_INDEX, w);
            wr(OFS_CMD_WORD, 32'h1122 + (w - 1) * 32'h2222);
        end
        launch(CMD_KEY_VERIFY, d);
        chk(rel, 1'b1);
        rd(OFS_SECURITY, d);
        chk(d[SEC_SECURED_BIT], 1'b0);
        wr(OFS_INDEX, 32'h3);
        rd(OFS_CMD_WORD, d);
        chk(d, 32'h5566);
        final_report();
    end
endmodule // tb_top
`default_nettype wire
